// ### rtl/adc_cfg_pkg.sv
package adc_cfg_pkg;
  // ==========================================
  // Bus and register map
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int LANE_COUNT = 16;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FULLSCALE_B = 8'h32;
  localparam logic [7:0] IDX_REF_BYPASS = 8'h38;
  localparam logic [7:0] IDX_TIMESTAMP = 8'h3B;
  localparam logic [7:0] IDX_EMPHASIS = 8'h48;
  localparam logic [7:0] IDX_ROUTING = 8'h60;
  // ==========================================
  // Reset values
  localparam logic [15:0] RST_FULLSCALE_B = 16'hA000;
  localparam logic [7:0] RST_REF_BYPASS = 8'h00;
  localparam logic [7:0] RST_TIMESTAMP = 8'h00;
  localparam logic [7:0] RST_EMPHASIS = 8'h00;
  localparam logic [7:0] RST_ROUTING = 8'h01;
  // ==========================================
  // Field positions
  localparam int BIT_REF_BYPASS = 0;
  localparam int BIT_TS_ENABLE = 0;
  localparam int BIT_TS_PECL = 1;
  localparam int PE_LSB = 0;
  localparam int PE_MSB = 2;
  localparam int BIT_PE_BOOST = 3;
  localparam int BIT_DUAL_SWAP = 4;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 1;
  // ==========================================
  // Single-channel input select codes
  localparam logic [1:0] SEL_RESERVED = 2'h0;
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam logic [1:0] SEL_INTERLEAVED = 2'h3;
  // ==========================================
  // Full-scale transfer points
  localparam int FS_CODE_MIN = 32'h2000;
  localparam int FS_CODE_DEF = 32'hA000;
  localparam int FS_CODE_MAX = 32'hFFFF;
  localparam int FS_MV_MIN = 500;
  localparam int FS_MV_DEF = 800;
  localparam int FS_MV_MAX = 1000;
  localparam int FS_MV_W = 10;
  // ==========================================
  // Carriers
  typedef enum logic [1:0] {SRC_NONE, SRC_A, SRC_B} input_src_e;
  typedef struct packed {
    input_src_e chan_a;
    input_src_e chan_b;
  } routing_s;
  typedef struct packed {
    logic [2:0] level;
    logic boost;
  } emphasis_s;
  typedef struct packed {
    logic enable;
    logic lowvolt_pecl;
  } timestamp_s;
endpackage

// ### rtl/fullscale_mapper.sv
`timescale 1ns/10ps
module fullscale_mapper
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Code in, range out
  input wire logic [15:0] code,
  output logic [FS_MV_W-1:0] range_mv,
  output logic degraded
);
  // ==========================================
  // Piecewise-linear code to mVpp
  // Two segments because the points are not collinear
  function automatic logic [FS_MV_W-1:0] to_mv(input logic [15:0] c);
    int v;
    int mv;
    v = int'(c);
    if (v >= FS_CODE_DEF) begin
      mv = FS_MV_DEF + ((v - FS_CODE_DEF) * (FS_MV_MAX - FS_MV_DEF))
           / (FS_CODE_MAX - FS_CODE_DEF);
    end else begin
      mv = FS_MV_MIN + ((v - FS_CODE_MIN) * (FS_MV_DEF - FS_MV_MIN))
           / (FS_CODE_DEF - FS_CODE_MIN);
    end
    return mv[FS_MV_W-1:0];
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_mv <= FS_MV_W'(FS_MV_DEF);
      degraded <= 1'b0;
    end else begin
      range_mv <= to_mv(code); // RULE1
      degraded <= (int'(code) < FS_CODE_MIN); // RULE1
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  fs_min_point_a: assert property (code == 16'h2000 |=> range_mv == 10'h1F4) // RULE1
    else $error("min code not 500 mVpp");
  fs_def_point_a: assert property (code == 16'hA000 |=> range_mv == 10'h320) // RULE1
    else $error("default code not 800 mVpp");
  fs_max_point_a: assert property (code == 16'hFFFF |=> range_mv == 10'h3E8) // RULE1
    else $error("max code not 1000 mVpp");
  fs_degraded_a: assert property ($rose(degraded) |-> $past(code) < 16'h2000) // RULE1
    else $error("degraded flag without low code");
endmodule

// ### rtl/input_router.sv
`timescale 1ns/10ps
module input_router
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings
  input wire logic single_channel_mode,
  input wire logic [1:0] single_select,
  input wire logic dual_swap,
  input wire logic calibration_done,
  // Routing applied to the converter cores
  output routing_s routing,
  output logic routing_pending
);
  // ==========================================
  function automatic routing_s decode(input logic single, input logic [1:0] sel,
                                      input logic swap);
    routing_s r;
    r = '{chan_a: SRC_A, chan_b: SRC_B};
    if (single) begin
      unique case (sel)
        SEL_RESERVED: r = '{chan_a: SRC_NONE, chan_b: SRC_NONE};
        SEL_A: r = '{chan_a: SRC_A, chan_b: SRC_A};
        SEL_B: r = '{chan_a: SRC_B, chan_b: SRC_B};
        SEL_INTERLEAVED: r = '{chan_a: SRC_A, chan_b: SRC_B};
      endcase
    end else if (swap) begin
      r = '{chan_a: SRC_B, chan_b: SRC_A};
    end
    return r;
  endfunction

  routing_s requested;
  assign requested = decode(single_channel_mode, single_select, dual_swap); // RULE7 RULE8

  // New routing waits for calibration so the cores never see a half-switched input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routing <= '{chan_a: SRC_A, chan_b: SRC_A};
    end else if (calibration_done) begin
      routing <= requested; // RULE9
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routing_pending <= 1'b0;
    end else begin
      routing_pending <= !calibration_done && (requested != routing);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  route_apply_a: assert property (calibration_done |=> routing == $past(requested)) // RULE9
    else $error("routing not applied after calibration");
  route_hold_a: assert property (!calibration_done |=> $stable(routing)) // RULE9
    else $error("routing changed without calibration");
  dual_swap_a: assert property (calibration_done && !single_channel_mode && dual_swap // RULE7
      |=> routing == routing_s'{chan_a: SRC_B, chan_b: SRC_A})
    else $error("dual swap not applied");
  single_b_a: assert property (calibration_done && single_channel_mode // RULE8
      && single_select == SEL_B |=> routing == routing_s'{chan_a: SRC_B, chan_b: SRC_B})
    else $error("single input B not applied");
endmodule

// ### rtl/adc_input_config_registers.sv
// Behaviour
// RULE1: The input B full-scale code maps onto 500, 800 and 1000 mVpp at 0x2000, 0xA000, 0xFFFF.
// RULE2: Reference bypass bit 0 set selects the 1.1 V analog supply instead of the band-gap.
// RULE3: Timestamp control bit 0 enables the timestamp receiver, off after reset.
// RULE4: Timestamp control bit 1 puts the timestamp receiver in low-voltage PECL mode.
// RULE5: Pre-emphasis bits 2:0 drive all 16 lanes alike, resetting to zero.
// RULE6: Pre-emphasis bit 3 adds a boost on every lane.
// RULE7: In dual-channel modes bit 4 of the input mux swaps the inputs of the two channels.
// RULE8: In single-channel modes bits 1:0 pick reserved, input A, input B or interleaved A/B.
// RULE9: Software runs a calibration after changing the mux before the routing takes effect.
// RULE10: Reset loads input mux 0x01 and zero into bypass, timestamp and pre-emphasis.
// RULE11: Reserved bits should be written zero and read back as stored, with no effect.
`timescale 1ns/10ps
module adc_input_config_registers
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [adc_cfg_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [adc_cfg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter status in
  input wire logic single_channel_mode,
  input wire logic calibration_done,
  // Timestamp pin
  input wire logic timestamp_input,
  // Analog controls
  output logic [15:0] input_b_fullscale_code,
  output logic [adc_cfg_pkg::FS_MV_W-1:0] input_b_fullscale_mv,
  output logic fullscale_degraded,
  output logic reference_bypass,
  // Timestamp receiver
  output adc_cfg_pkg::timestamp_s timestamp_ctrl,
  output logic timestamp_event,
  // Serializer lanes
  output adc_cfg_pkg::emphasis_s [adc_cfg_pkg::LANE_COUNT-1:0] lane_emphasis,
  // Input routing
  output adc_cfg_pkg::routing_s routing,
  output logic routing_pending
);
  import adc_cfg_pkg::*;

  // ==========================================
  // Register storage
  logic [15:0] fullscale_b;
  logic [7:0] reference_bypass_ctrl;
  logic [7:0] timestamp_input_ctrl;
  logic [7:0] serializer_emphasis_ctrl;
  logic [7:0] input_routing_ctrl;

  // ==========================================
  // Address decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return hit(a, IDX_FULLSCALE_B) || hit(a, IDX_REF_BYPASS)
        || hit(a, IDX_TIMESTAMP) || hit(a, IDX_EMPHASIS)
        || hit(a, IDX_ROUTING);
  endfunction

  function automatic logic [DATA_W-1:0] byte_word(input logic [7:0] b);
    return {24'h000000, b};
  endfunction

  logic setup_phase;
  logic write_now;
  assign setup_phase = psel && !penable;
  assign write_now = psel && penable && pready && pwrite && !pslverr;

  // ==========================================
  // APB answer: no wait states, reply flopped in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // Unmapped addresses answer with an error and no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase && !mapped(paddr);
    end
  end

  logic [DATA_W-1:0] next_prdata;
  always_comb begin
    next_prdata = '0;
    if (hit(paddr, IDX_FULLSCALE_B)) begin
      next_prdata = {16'h0000, fullscale_b};
    end else if (hit(paddr, IDX_REF_BYPASS)) begin
      next_prdata = byte_word(reference_bypass_ctrl); // RULE11
    end else if (hit(paddr, IDX_TIMESTAMP)) begin
      next_prdata = byte_word(timestamp_input_ctrl); // RULE11
    end else if (hit(paddr, IDX_EMPHASIS)) begin
      next_prdata = byte_word(serializer_emphasis_ctrl); // RULE11
    end else if (hit(paddr, IDX_ROUTING)) begin
      next_prdata = byte_word(input_routing_ctrl); // RULE11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================
  // Register writes; reserved bits are kept as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fullscale_b <= RST_FULLSCALE_B;
    end else if (write_now && hit(paddr, IDX_FULLSCALE_B)) begin
      if (pstrb[0]) begin
        fullscale_b[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        fullscale_b[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_bypass_ctrl <= RST_REF_BYPASS; // RULE10
    end else if (write_now && pstrb[0] && hit(paddr, IDX_REF_BYPASS)) begin
      reference_bypass_ctrl <= pwdata[7:0]; // RULE11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timestamp_input_ctrl <= RST_TIMESTAMP; // RULE10
    end else if (write_now && pstrb[0] && hit(paddr, IDX_TIMESTAMP)) begin
      timestamp_input_ctrl <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serializer_emphasis_ctrl <= RST_EMPHASIS; // RULE10
    end else if (write_now && pstrb[0] && hit(paddr, IDX_EMPHASIS)) begin
      serializer_emphasis_ctrl <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_routing_ctrl <= RST_ROUTING; // RULE10
    end else if (write_now && pstrb[0] && hit(paddr, IDX_ROUTING)) begin
      input_routing_ctrl <= pwdata[7:0];
    end
  end

  // ==========================================
  // Analog and serializer controls
  assign input_b_fullscale_code = fullscale_b;
  assign reference_bypass = reference_bypass_ctrl[BIT_REF_BYPASS]; // RULE2
  assign timestamp_ctrl = timestamp_s'{
    enable: timestamp_input_ctrl[BIT_TS_ENABLE], // RULE3
    lowvolt_pecl: timestamp_input_ctrl[BIT_TS_PECL] // RULE4
  };

  // One shared field: no lane can drift from the others
  emphasis_s emphasis;
  assign emphasis = emphasis_s'{
    level: serializer_emphasis_ctrl[PE_MSB:PE_LSB], // RULE5
    boost: serializer_emphasis_ctrl[BIT_PE_BOOST] // RULE6
  };
  assign lane_emphasis = {LANE_COUNT{emphasis}}; // RULE5

  fullscale_mapper u_fullscale (
    .pclk(pclk),
    .presetn(presetn),
    .code(fullscale_b),
    .range_mv(input_b_fullscale_mv),
    .degraded(fullscale_degraded)
  );

  input_router u_router (
    .pclk(pclk),
    .presetn(presetn),
    .single_channel_mode(single_channel_mode),
    .single_select(input_routing_ctrl[SEL_MSB:SEL_LSB]),
    .dual_swap(input_routing_ctrl[BIT_DUAL_SWAP]),
    .calibration_done(calibration_done),
    .routing(routing),
    .routing_pending(routing_pending)
  );

  // ==========================================
  // Timestamp pin: synchronised, passed only while the receiver is on
  logic ts_meta;
  logic ts_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_meta <= 1'b0;
      ts_sync <= 1'b0;
    end else begin
      ts_meta <= timestamp_input;
      ts_sync <= ts_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timestamp_event <= 1'b0;
    end else begin
      timestamp_event <= ts_sync && timestamp_input_ctrl[BIT_TS_ENABLE]; // RULE3
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence wr_to(logic [7:0] idx);
    psel && penable && pready && pwrite && pstrb[0]
      && paddr == ADDR_W'({idx, 2'b00});
  endsequence

  reset_values_a: assert property ($rose(presetn) |-> input_routing_ctrl == 8'h01 // RULE10
      && reference_bypass_ctrl == 8'h00 && timestamp_input_ctrl == 8'h00
      && serializer_emphasis_ctrl == 8'h00)
    else $error("wrong value after reset");
  bypass_write_a: assert property (wr_to(IDX_REF_BYPASS) // RULE2
      |=> reference_bypass == $past(pwdata[0]))
    else $error("bypass output not following write");
  ts_enable_a: assert property (wr_to(IDX_TIMESTAMP) // RULE3
      |=> timestamp_ctrl.enable == $past(pwdata[0]))
    else $error("timestamp enable not following write");
  ts_pecl_a: assert property (wr_to(IDX_TIMESTAMP) // RULE4
      |=> timestamp_ctrl.lowvolt_pecl == $past(pwdata[1]))
    else $error("pecl mode not following write");
  ts_gated_a: assert property (!timestamp_ctrl.enable |=> !timestamp_event) // RULE3
    else $error("timestamp event while receiver off");
  lanes_equal_a: assert property (wr_to(IDX_EMPHASIS) // RULE5
      |=> lane_emphasis[LANE_COUNT-1].level == $past(pwdata[2:0])
          && lane_emphasis[0].level == $past(pwdata[2:0]))
    else $error("lane pre-emphasis not global");
  boost_write_a: assert property (wr_to(IDX_EMPHASIS) // RULE6
      |=> lane_emphasis[7].boost == $past(pwdata[3]))
    else $error("boost not applied to lanes");
  reserved_kept_a: assert property (wr_to(IDX_ROUTING) ##1 (psel && !penable && !pwrite // RULE11
      && paddr == ADDR_W'({IDX_ROUTING, 2'b00})) |=> prdata[7:0] == $past(pwdata[7:0], 2))
    else $error("routing register readback differs");
  unmapped_err_a: assert property (psel && !penable && !mapped(paddr) |=> pready && pslverr)
    else $error("unmapped access not refused");

  // ==========================================
  // Bus answer and readback checks
  sequence rd_setup(logic [7:0] idx);
    psel && !penable && !pwrite && paddr == ADDR_W'({idx, 2'b00});
  endsequence

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  mapped_ok_a: assert property (psel && !penable && mapped(paddr) |=> pready && !pslverr)
    else $error("mapped access refused");
  err_read_zero_a: assert property (psel && !penable && !pwrite && !mapped(paddr)
      |=> prdata == '0)
    else $error("refused read returned data");
  err_no_write_a: assert property (pready && pslverr |=> $stable(fullscale_b)
      && $stable(reference_bypass_ctrl) && $stable(timestamp_input_ctrl)
      && $stable(serializer_emphasis_ctrl) && $stable(input_routing_ctrl))
    else $error("refused write changed a register");
  fs_reset_a: assert property ($rose(presetn) |-> fullscale_b == RST_FULLSCALE_B) // RULE1
    else $error("full-scale code not default after reset");
  fs_low_write_a: assert property (wr_to(IDX_FULLSCALE_B) // RULE1
      |=> input_b_fullscale_code[7:0] == $past(pwdata[7:0]))
    else $error("full-scale low byte not written");
  fs_high_write_a: assert property (psel && penable && pready && pwrite && pstrb[1] // RULE1
      && paddr == ADDR_W'({IDX_FULLSCALE_B, 2'b00})
      |=> input_b_fullscale_code[15:8] == $past(pwdata[15:8]))
    else $error("full-scale high byte not written");
  fs_readback_a: assert property (rd_setup(IDX_FULLSCALE_B) // RULE1
      |=> prdata == {16'h0000, $past(fullscale_b)})
    else $error("full-scale readback differs");
  bypass_readback_a: assert property (rd_setup(IDX_REF_BYPASS) // RULE2
      |=> prdata == byte_word($past(reference_bypass_ctrl)))
    else $error("bypass readback differs");
  ts_readback_a: assert property (rd_setup(IDX_TIMESTAMP) // RULE3
      |=> prdata == byte_word($past(timestamp_input_ctrl)))
    else $error("timestamp control readback differs");
  routing_write_a: assert property (wr_to(IDX_ROUTING) // RULE8
      |=> input_routing_ctrl == $past(pwdata[7:0]))
    else $error("routing register not written");
  ts_pin_event_a: assert property (timestamp_ctrl.enable && ts_sync // RULE3
      |=> timestamp_event)
    else $error("timestamp event lost while receiver on");
endmodule

// ### bench/adc_input_config_registers_tb.sv
`timescale 1ns/10ps
module adc_input_config_registers_tb;
  import adc_cfg_pkg::*;
  // ==========================================
  // Signals
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic [3:0] pstrb;
  logic pready;
  logic pslverr;
  logic single_channel_mode;
  logic calibration_done;
  logic timestamp_input;
  logic [15:0] input_b_fullscale_code;
  logic [FS_MV_W-1:0] input_b_fullscale_mv;
  logic fullscale_degraded;
  logic reference_bypass;
  logic timestamp_event;
  logic routing_pending;
  timestamp_s timestamp_ctrl;
  emphasis_s [LANE_COUNT-1:0] lane_emphasis;
  routing_s routing;
  routing_s applied;
  routing_s wanted;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [DATA_W-1:0] rd;
  logic er;
  logic keep_bus = 1'b0;
  logic bus_held = 1'b0;
  logic [7:0] idxs [5] = '{IDX_FULLSCALE_B, IDX_REF_BYPASS, IDX_TIMESTAMP, IDX_EMPHASIS,
                           IDX_ROUTING};
  logic [31:0] rsts [5] = '{32'(RST_FULLSCALE_B), 32'(RST_REF_BYPASS), 32'(RST_TIMESTAMP),
                            32'(RST_EMPHASIS), 32'(RST_ROUTING)};
  logic [15:0] codes [4] = '{16'h2000, 16'hA000, 16'hFFFF, 16'h1000};

  adc_input_config_registers dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .single_channel_mode(single_channel_mode),
    .calibration_done(calibration_done), .timestamp_input(timestamp_input),
    .input_b_fullscale_code(input_b_fullscale_code),
    .input_b_fullscale_mv(input_b_fullscale_mv), .fullscale_degraded(fullscale_degraded),
    .reference_bypass(reference_bypass), .timestamp_ctrl(timestamp_ctrl),
    .timestamp_event(timestamp_event), .lane_emphasis(lane_emphasis), .routing(routing),
    .routing_pending(routing_pending)
  );

  // ==========================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("ERROR %0t: run did not finish in time", $time);
      summarize();
    end
  end

  // ==========================================
  // Helpers
  function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction

  // Two linear pieces meeting at the default point
  function automatic int fs_mv(input int c);
    if (c < FS_CODE_DEF) begin
      return FS_MV_MIN + (c - FS_CODE_MIN) * (FS_MV_DEF - FS_MV_MIN) / (FS_CODE_DEF - FS_CODE_MIN);
    end
    return FS_MV_DEF + (c - FS_CODE_DEF) * (FS_MV_MAX - FS_MV_DEF) / (FS_CODE_MAX - FS_CODE_DEF);
  endfunction

  function automatic routing_s route(input logic single, input logic [7:0] v);
    if (!single) begin
      return v[4] ? routing_s'{SRC_B, SRC_A} : routing_s'{SRC_A, SRC_B};
    end
    case (v[1:0])
      2'h0: return '{SRC_NONE, SRC_NONE};
      2'h1: return '{SRC_A, SRC_A};
      2'h2: return '{SRC_B, SRC_B};
      default: return '{SRC_A, SRC_B};
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is sampled high at a rising edge; keep_bus chains the next setup
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    if (!bus_held) begin
      @(posedge pclk);
    end
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    if (!keep_bus) begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
    bus_held = keep_bus;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic summarize();
    $display("Checks: %0d, mismatches: %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] v;
    logic [15:0] c;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    single_channel_mode = 1'b1;
    calibration_done = 1'b0;
    timestamp_input = 1'b0;
    applied = '{SRC_A, SRC_A};
    void'($urandom(64));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    check(input_b_fullscale_mv, FS_MV_DEF);
    check({reference_bypass, timestamp_ctrl, |lane_emphasis}, 0);
    check(routing, applied);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ba(idxs[i]), 0, 4'h0);
      check(rd, rsts[i]);
    end
    // Unmapped place: refused both ways
    apb(1'b0, 12'h004, 0, 4'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, 12'h004, 32'hFF, 4'hF);
    check(er, 1'b1);
    for (int i = 0; i < 10; i++) begin
      c = (i < 4) ? codes[i] : 16'(16'h2000 + $urandom % 32'hE000);
      apb(1'b1, ba(IDX_FULLSCALE_B), 32'(c), 4'hF);
      settle(2);
      check(input_b_fullscale_code, c);
      check(input_b_fullscale_mv, fs_mv(int'(c)));
      check(fullscale_degraded, c < 16'h2000);
    end
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h01 : (i == 1) ? 32'hFE : 32'($urandom % 256);
      apb(1'b1, ba(IDX_REF_BYPASS), v, 4'hF);
      settle(1);
      check(reference_bypass, v[0]);
      apb(1'b0, ba(IDX_REF_BYPASS), 0, 4'h0);
      check(rd, v);
    end
    for (int i = 0; i < 5; i++) begin
      v = (i < 4) ? 32'(i) : 32'($urandom % 4);
      apb(1'b1, ba(IDX_TIMESTAMP), v, 4'hF);
      settle(1);
      check(timestamp_ctrl.enable, v[0]);
      check(timestamp_ctrl.lowvolt_pecl, v[1]);
      @(posedge pclk);
      timestamp_input <= 1'b1;
      settle(5);
      check(timestamp_event, v[0]);
      @(posedge pclk);
      timestamp_input <= 1'b0;
      settle(5);
      check(timestamp_event, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'hF : 32'($urandom % 16);
      apb(1'b1, ba(IDX_EMPHASIS), v, 4'hF);
      settle(1);
      for (int l = 0; l < LANE_COUNT; l++) begin
        check(lane_emphasis[l].level, v[2:0]);
        check(lane_emphasis[l].boost, v[3]);
      end
    end
    // Single-channel codes first, then both dual-channel routings
    for (int m = 1; m >= 0; m--) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge pclk);
        single_channel_mode <= m[0];
        v = m ? 32'(k | (($urandom % 2) << 4)) : 32'((k[0] << 4) | ($urandom % 4));
        wanted = route(m[0], v[7:0]);
        // Write and read back with no idle cycle between
        keep_bus = 1'b1;
        apb(1'b1, ba(IDX_ROUTING), v, 4'hF);
        keep_bus = 1'b0;
        apb(1'b0, ba(IDX_ROUTING), 0, 4'h0);
        check(rd, v);
        settle(3);
        check(routing, applied);
        check(routing_pending, wanted != applied);
        @(posedge pclk);
        calibration_done <= 1'b1;
        @(posedge pclk);
        calibration_done <= 1'b0;
        settle(3);
        applied = wanted;
        check(routing, applied);
        check(routing_pending, 1'b0);
      end
    end
    // Second reset in mid-run brings every register back
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    check(routing, routing_s'{SRC_A, SRC_A});
    check(input_b_fullscale_mv, FS_MV_DEF);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ba(idxs[i]), 0, 4'h0);
      check(rd, rsts[i]);
    end
    summarize();
  end
endmodule
